// [logic/dps_core.sv]
`timescale 1ns/100ps
// How it works
// - beside the self-test, limit, fault and error pins, the host moves the state through the command word and reads it back only from the report word.
// - command word bits 7,3,2,1,0 decode into shutdown, switch on, disable voltage, quick stop, disable and enable operation.
// - bits marked don't-care for a command are masked out before the pattern is compared.
// - fault reset and the return from quick stop react to a rising edge of the command, not to its level.
// - from quick stop active, bits 3,1,0 set with bit 7 clear bring the drive back to operation enabled.
// - the report word carries the state in bits 6, 5 and 3..0 using the fixed eight codes.
// - once power-up self-test passes the machine moves to switch on disabled.
// - an unrecoverable error parks the machine in not ready to switch on for good.
// - the requested operating mode and the mode in effect are two separate registers, the latter read-only.
// - the requested operating mode may be written in any state.
// - quick stop code 0 stops at once and then drops to switch on disabled.
// - codes 1 and 2 brake on the slow or quick ramp and then drop to switch on disabled.
// - codes 5 and 6 brake and then hold quick stop active with power on, allowing a return.
// - an actuated limit switch in operation enabled also forces quick stop active.
module dps_core (
	// clock, reset, freeze
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// axi4-lite write
	input wire logic [dps_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [dps_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// drive side
	input wire logic selftest_ok,
	input wire logic unrecoverable_err,
	input wire logic fault_req,
	input wire logic limit_hit,
	output logic power_enabled,
	output logic braking,
	output logic brake_quick_ramp,
	output logic irq
);
	import dps_pkg::*;

	// ==========================================================
	// registers
	logic [15:0] cmd_q;
	logic [15:0] cmd_prev_q;
	logic [15:0] qs_code_q;
	logic [7:0] mode_req_q;
	logic [7:0] mode_act_q;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_stat_d;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [IRQ_W-1:0] irq_mask_d;
	logic irq_q;
	logic dead_q;
	logic power_q;
	dps_state_t state_q;
	dps_state_t state_d;

	// ==========================================================
	// bus slave
	logic aw_hold_q;
	logic w_hold_q;
	logic [IDX_W-1:0] aw_idx_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	assign s_axi_awready = ce && !aw_hold_q && !bvalid_q;
	assign s_axi_wready = ce && !w_hold_q && !bvalid_q;
	assign s_axi_arready = ce && !rvalid_q;
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire ar_take = s_axi_arvalid && s_axi_arready;
	wire wr_fire = ce && aw_hold_q && w_hold_q && !bvalid_q;

	wire wr_cmd = wr_fire && (aw_idx_q == IDX_CMD);
	wire wr_qs = wr_fire && (aw_idx_q == IDX_QS_CODE);
	wire wr_mode = wr_fire && (aw_idx_q == IDX_MODE_REQ) && w_strb_q[0];
	wire wr_mask = wr_fire && (aw_idx_q == IDX_IRQ_MASK) && w_strb_q[0];
	wire wr_known = (aw_idx_q == IDX_CMD) || (aw_idx_q == IDX_STAT)
		|| (aw_idx_q == IDX_QS_CODE) || (aw_idx_q == IDX_MODE_REQ)
		|| (aw_idx_q == IDX_MODE_ACT) || (aw_idx_q == IDX_IRQ_STAT)
		|| (aw_idx_q == IDX_IRQ_MASK);

	wire [IDX_W-1:0] ar_idx = s_axi_araddr[ADDR_W-1:2];
	wire [15:0] status_word;
	wire rd_stat_clr = ar_take && (ar_idx == IDX_IRQ_STAT);
	wire rd_known = (ar_idx == IDX_CMD) || (ar_idx == IDX_STAT)
		|| (ar_idx == IDX_QS_CODE) || (ar_idx == IDX_MODE_REQ)
		|| (ar_idx == IDX_MODE_ACT) || (ar_idx == IDX_IRQ_STAT)
		|| (ar_idx == IDX_IRQ_MASK);
	wire [31:0] rd_mux =
		(ar_idx == IDX_CMD) ? {16'h0000, cmd_q} :
		(ar_idx == IDX_STAT) ? {16'h0000, status_word} :
		(ar_idx == IDX_QS_CODE) ? {16'h0000, qs_code_q} :
		(ar_idx == IDX_MODE_REQ) ? {24'h000000, mode_req_q} :
		(ar_idx == IDX_MODE_ACT) ? {24'h000000, mode_act_q} :
		(ar_idx == IDX_IRQ_STAT) ? {29'h00000000, irq_stat_q} :
		(ar_idx == IDX_IRQ_MASK) ? {29'h00000000, irq_mask_q} : 32'h00000000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			aw_idx_q <= '0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (ce) begin
			if (aw_take) begin
				aw_hold_q <= 1'b1;
				aw_idx_q <= s_axi_awaddr[ADDR_W-1:2];
			end
			if (w_take) begin
				w_hold_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= RESP_OKAY;
		end else if (ce) begin
			if (ar_take) begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_mux;
				rresp_q <= rd_known ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// ==========================================================
	// command decode; masking keeps don't-care bits out
	wire [4:0] cw = {cmd_q[CW_FR], cmd_q[CW_EO], cmd_q[CW_QS], cmd_q[CW_EV], cmd_q[CW_ON]};
	wire [4:0] cw_prev = {cmd_prev_q[CW_FR], cmd_prev_q[CW_EO], cmd_prev_q[CW_QS],
		cmd_prev_q[CW_EV], cmd_prev_q[CW_ON]};
	wire c_shut = cmd_is(cw, CARE_SHUT, VAL_SHUT);
	wire c_swon = cmd_is(cw, CARE_SWON, VAL_SWON);
	wire c_disv = cmd_is(cw, CARE_DISV, VAL_DISV);
	wire c_qstop = cmd_is(cw, CARE_QSTOP, VAL_QSTOP);
	wire c_enop = cmd_is(cw, CARE_ENOP, VAL_ENOP);
	// edge only: a held pattern cannot re-enter after a fresh quick stop
	wire enqs_rise = cmd_is(cw, CARE_ENQS, VAL_ENQS)
		&& !cmd_is(cw_prev, CARE_ENQS, VAL_ENQS);
	wire fr_rise = cw[4] && !cw_prev[4];

	wire qs_hold = (qs_code_q == QS_SLOW_HOLD) || (qs_code_q == QS_QUICK_HOLD);
	wire qs_slow = (qs_code_q == QS_SLOW_OFF) || (qs_code_q == QS_SLOW_HOLD);
	wire qs_imm = (qs_code_q == QS_IMMEDIATE);

	wire ramp_busy;
	wire ramp_done;
	wire ramp_quick;

	// ==========================================================
	// power state machine
	always_comb begin
		state_d = state_q;
		case (state_q)
			S_NOT_READY: begin
				if (selftest_ok)
					state_d = S_SW_ON_DIS;
			end
			S_SW_ON_DIS: begin
				if (c_shut)
					state_d = S_READY;
			end
			S_READY: begin
				if (c_disv || c_qstop)
					state_d = S_SW_ON_DIS;
				else if (c_swon)
					state_d = S_SWITCHED_ON;
			end
			S_SWITCHED_ON: begin
				if (c_disv || c_qstop)
					state_d = S_SW_ON_DIS;
				else if (c_shut)
					state_d = S_READY;
				else if (c_enop)
					state_d = S_OP_EN;
			end
			S_OP_EN: begin
				if (c_disv)
					state_d = S_SW_ON_DIS;
				else if (c_qstop || limit_hit)
					state_d = S_QSTOP;
				else if (c_shut)
					state_d = S_READY;
				else if (c_swon)
					state_d = S_SWITCHED_ON;
			end
			S_QSTOP: begin
				if (c_disv || qs_imm)
					state_d = S_SW_ON_DIS;
				else if (!qs_hold && ramp_done)
					state_d = S_SW_ON_DIS;
				else if (qs_hold && !ramp_busy && !ramp_done && enqs_rise)
					state_d = S_OP_EN;
			end
			S_FAULT_REACT: begin
				if (ramp_done)
					state_d = S_FAULT;
			end
			S_FAULT: begin
				if (fr_rise)
					state_d = S_SW_ON_DIS;
			end
			default: state_d = S_NOT_READY;
		endcase
		if (fault_req && (state_q != S_NOT_READY) && (state_q != S_FAULT_REACT)
			&& (state_q != S_FAULT))
			state_d = S_FAULT_REACT;
		if (dead_q || unrecoverable_err)
			state_d = S_NOT_READY;
	end

	wire entering = (state_d != state_q);
	wire ramp_start = entering && (((state_d == S_QSTOP) && !qs_imm)
		|| (state_d == S_FAULT_REACT));
	wire ramp_sel_quick = (state_d == S_FAULT_REACT) || !qs_slow;

	dps_ramp u_ramp (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.start(ramp_start),
		.quick(ramp_sel_quick),
		.busy(ramp_busy),
		.quick_sel(ramp_quick),
		.done(ramp_done)
	);

	assign status_word =
		(state_q == S_SW_ON_DIS) ? SW_SW_ON_DIS :
		(state_q == S_READY) ? SW_READY :
		(state_q == S_SWITCHED_ON) ? SW_SWITCHED_ON :
		(state_q == S_OP_EN) ? SW_OP_EN :
		(state_q == S_QSTOP) ? SW_QSTOP :
		(state_q == S_FAULT_REACT) ? SW_FAULT_REACT :
		(state_q == S_FAULT) ? SW_FAULT : SW_NOT_READY;

	// ==========================================================
	// interrupts: set beats read-clear
	wire [IRQ_W-1:0] irq_set = {
		entering && (state_d == S_FAULT_REACT || state_d == S_NOT_READY),
		entering && (state_d == S_QSTOP),
		entering};
	assign irq_stat_d = (irq_stat_q & ~{IRQ_W{rd_stat_clr}}) | irq_set;
	assign irq_mask_d = wr_mask ? w_data_q[IRQ_W-1:0] : irq_mask_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= S_NOT_READY;
			dead_q <= 1'b0;
			cmd_q <= CMD_RST;
			cmd_prev_q <= CMD_RST;
			qs_code_q <= QS_CODE_RST;
			mode_req_q <= MODE_RST;
			mode_act_q <= MODE_RST;
			irq_stat_q <= '0;
			irq_mask_q <= IRQ_MASK_RST;
			irq_q <= 1'b0;
			power_q <= 1'b0;
		end else if (ce) begin
			state_q <= state_d;
			dead_q <= dead_q || unrecoverable_err;
			cmd_prev_q <= cmd_q;
			if (wr_cmd)
				cmd_q <= lane16(cmd_q, w_data_q[15:0], w_strb_q[1:0]);
			if (wr_qs)
				qs_code_q <= lane16(qs_code_q, w_data_q[15:0], w_strb_q[1:0]);
			if (wr_mode)
				mode_req_q <= w_data_q[7:0];
			// mode switches only once braking is over
			if (!ramp_busy)
				mode_act_q <= mode_req_q;
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
			irq_q <= |(irq_stat_d & irq_mask_d);
			power_q <= (state_d == S_OP_EN) || (state_d == S_QSTOP && !qs_imm);
		end
	end

	assign power_enabled = power_q;
	assign braking = ramp_busy;
	assign brake_quick_ramp = ramp_quick;
	assign irq = irq_q;

	// ==========================================================
	// checks
	default clocking dps_cb @(posedge aclk iff ce);
	endclocking
	default disable iff (!aresetn);

	a_dead_parked: assert property (dead_q |-> state_q == S_NOT_READY && status_word[6] == 1'b0)
		else $error("unrecoverable error left not ready");
	a_selftest_entry: assert property (state_q == S_NOT_READY && selftest_ok && !dead_q
		&& !unrecoverable_err |=> state_q == S_SW_ON_DIS)
		else $error("self test did not reach switch on disabled");
	a_op_code: assert property (state_q == S_OP_EN |-> status_word[6:5] == 2'b01
		&& status_word[3:0] == 4'h7)
		else $error("operation enabled code wrong");
	a_enable_op: assert property (state_q == S_SWITCHED_ON && c_enop && !fault_req
		&& !dead_q && !unrecoverable_err |=> state_q == S_OP_EN)
		else $error("enable operation not taken");
	a_qs_immediate: assert property (state_q == S_QSTOP && qs_imm && !fault_req && !dead_q
		&& !unrecoverable_err |=> state_q == S_SW_ON_DIS)
		else $error("immediate quick stop did not drop");
	a_qs_ramp_off: assert property ($rose(state_q == S_QSTOP) && qs_code_q == QS_QUICK_OFF
		&& $stable(qs_code_q) |-> ramp_busy ##[1:260] state_q != S_QSTOP)
		else $error("quick ramp did not end the quick stop");
	a_qs_hold: assert property (state_q == S_QSTOP && qs_hold && !enqs_rise && !c_disv
		&& !fault_req && !dead_q && !unrecoverable_err |=> state_q == S_QSTOP)
		else $error("holding quick stop left the state");
	a_limit_stop: assert property (state_q == S_OP_EN && limit_hit && !c_disv && !fault_req
		&& !dead_q && !unrecoverable_err |=> state_q == S_QSTOP)
		else $error("limit switch did not force quick stop");
	a_level_only: assert property (state_q == S_QSTOP && qs_hold && !ramp_busy
		&& cmd_is(cw_prev, CARE_ENQS, VAL_ENQS) |=> state_q != S_OP_EN)
		else $error("return from quick stop taken on a level");
	a_mode_write: assert property (wr_mode |=> mode_req_q == $past(w_data_q[7:0]))
		else $error("mode request write lost");
	a_irq_level: assert property (irq == |(irq_stat_q & irq_mask_q))
		else $error("interrupt out of step with status");
endmodule

// [logic/dps_pkg.sv]
package dps_pkg;

	// ==========================================================
	// register bus
	localparam int ADDR_W = 20;
	localparam int IDX_W = 18;
	// register indices; the byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_CMD = 18'h06040;
	localparam logic [IDX_W-1:0] IDX_STAT = 18'h06041;
	localparam logic [IDX_W-1:0] IDX_QS_CODE = 18'h0605A;
	localparam logic [IDX_W-1:0] IDX_MODE_REQ = 18'h06060;
	localparam logic [IDX_W-1:0] IDX_MODE_ACT = 18'h06061;
	localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 18'h07000;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 18'h07001;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// reset values
	localparam logic [15:0] CMD_RST = 16'h0000;
	localparam logic [15:0] QS_CODE_RST = 16'h0002;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [2:0] IRQ_MASK_RST = 3'h0;

	// ==========================================================
	// command word bit positions
	localparam int CW_ON = 0;
	localparam int CW_EV = 1;
	localparam int CW_QS = 2;
	localparam int CW_EO = 3;
	localparam int CW_FR = 7;

	// command patterns over {b7,b3,b2,b1,b0}: care mask and value
	localparam logic [4:0] CARE_SHUT = 5'h17;
	localparam logic [4:0] VAL_SHUT = 5'h06;
	localparam logic [4:0] CARE_SWON = 5'h1F;
	localparam logic [4:0] VAL_SWON = 5'h07;
	localparam logic [4:0] CARE_DISV = 5'h12;
	localparam logic [4:0] VAL_DISV = 5'h00;
	localparam logic [4:0] CARE_QSTOP = 5'h16;
	localparam logic [4:0] VAL_QSTOP = 5'h02;
	localparam logic [4:0] CARE_ENOP = 5'h1F;
	localparam logic [4:0] VAL_ENOP = 5'h0F;
	localparam logic [4:0] CARE_ENQS = 5'h1B;
	localparam logic [4:0] VAL_ENQS = 5'h0B;

	// ==========================================================
	// report word codes (bits 6,5,3..0)
	localparam logic [15:0] SW_NOT_READY = 16'h0000;
	localparam logic [15:0] SW_SW_ON_DIS = 16'h0040;
	localparam logic [15:0] SW_READY = 16'h0021;
	localparam logic [15:0] SW_SWITCHED_ON = 16'h0023;
	localparam logic [15:0] SW_OP_EN = 16'h0027;
	localparam logic [15:0] SW_QSTOP = 16'h0007;
	localparam logic [15:0] SW_FAULT_REACT = 16'h000F;
	localparam logic [15:0] SW_FAULT = 16'h0008;

	// ==========================================================
	// quick stop reaction codes
	localparam logic [15:0] QS_IMMEDIATE = 16'h0000;
	localparam logic [15:0] QS_SLOW_OFF = 16'h0001;
	localparam logic [15:0] QS_QUICK_OFF = 16'h0002;
	localparam logic [15:0] QS_SLOW_HOLD = 16'h0005;
	localparam logic [15:0] QS_QUICK_HOLD = 16'h0006;

	// ==========================================================
	// interrupt status bits
	localparam int IRQ_W = 3;
	localparam int IRQ_STATE = 0;
	localparam int IRQ_QSTOP = 1;
	localparam int IRQ_FAULT = 2;

	// ==========================================================
	// braking ramp timing
	localparam int CLK_NS = 4;
	localparam int SLOW_RAMP_NS = 4000;
	localparam int QUICK_RAMP_NS = 1000;
	localparam int RAMP_W = 10;
	localparam logic [RAMP_W-1:0] SLOW_RAMP_CYC =
		RAMP_W'((SLOW_RAMP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [RAMP_W-1:0] QUICK_RAMP_CYC =
		RAMP_W'((QUICK_RAMP_NS + CLK_NS - 1) / CLK_NS);

	typedef enum logic [2:0] {
		S_NOT_READY, S_SW_ON_DIS, S_READY, S_SWITCHED_ON,
		S_OP_EN, S_QSTOP, S_FAULT_REACT, S_FAULT
	} dps_state_t;

	function automatic logic cmd_is(input logic [4:0] cw, input logic [4:0] care,
		input logic [4:0] val);
		return (cw & care) == val;
	endfunction

	function automatic logic [15:0] lane16(input logic [15:0] old, input logic [15:0] data,
		input logic [1:0] strb);
		return {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
	endfunction

endpackage

// [logic/dps_ramp.sv]
`timescale 1ns/100ps
module dps_ramp (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// control
	input wire logic start,
	input wire logic quick,
	// status
	output logic busy,
	output logic quick_sel,
	output logic done
);
	import dps_pkg::*;

	logic [RAMP_W-1:0] cnt_q;
	logic busy_q;
	logic quick_q;
	logic done_q;
	wire last = busy_q && (cnt_q == '0);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= '0;
			busy_q <= 1'b0;
			quick_q <= 1'b0;
			done_q <= 1'b0;
		end else if (ce) begin
			done_q <= last;
			if (start) begin
				cnt_q <= (quick ? QUICK_RAMP_CYC : SLOW_RAMP_CYC) - RAMP_W'(1);
				busy_q <= 1'b1;
				quick_q <= quick;
			end else if (last) begin
				busy_q <= 1'b0;
			end else if (busy_q) begin
				cnt_q <= cnt_q - RAMP_W'(1);
			end
		end
	end

	assign busy = busy_q;
	assign quick_sel = quick_q;
	assign done = done_q;
endmodule

// [test/dps_host.sv]
`timescale 1ns/100ps
// ==========================================================
// host model: one write and one read at a time
module dps_host (
	// clock
	input wire logic aclk,
	// write channels
	output logic [dps_pkg::ADDR_W-1:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	// read channels
	output logic [dps_pkg::ADDR_W-1:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	import dps_pkg::*;
	int tmo = 0;
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end
	// state changes are asked for only through register writes
	task automatic wr(input logic [IDX_W-1:0] i, input logic [15:0] d, output logic [1:0] rs);
		int n;
		n = 0;
		awaddr <= {i, 2'b00};
		awvalid <= 1'b1;
		wdata <= {16'h0000, d};
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (!(bvalid && bready) && n < 100);
		rs = bresp;
		// bready stays up between writes, so back-to-back calls never drive it twice at one edge
		if (n >= 100) begin
			{awvalid, wvalid} <= 2'h0;
			tmo++;
		end
	endtask
	task automatic rd(input logic [IDX_W-1:0] i, output logic [31:0] d, output logic [1:0] rs);
		int n;
		n = 0;
		araddr <= {i, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (!(rvalid && rready) && n < 100);
		d = rdata;
		rs = rresp;
		if (n >= 100) begin
			arvalid <= 1'b0;
			tmo++;
		end
	endtask
endmodule

// [test/tb.sv]
`timescale 1ns/100ps
`define CHK(s, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("mismatch %s expected %h seen %h", s, e, g); end end
module tb;
	import dps_pkg::*;
	logic aclk, aresetn, ce, selftest_ok, unrecoverable_err, fault_req, limit_hit;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic power_enabled, braking, brake_quick_ramp, irq;
	logic [15:0] m;
	logic [15:0] codes [5] = '{QS_IMMEDIATE, QS_SLOW_OFF, QS_QUICK_OFF, QS_SLOW_HOLD, QS_QUICK_HOLD};
	int error_cnt, total_checks, seed, n;
	dps_core u_dps_core (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.selftest_ok(selftest_ok), .unrecoverable_err(unrecoverable_err), .fault_req(fault_req),
		.limit_hit(limit_hit), .power_enabled(power_enabled), .braking(braking),
		.brake_quick_ramp(brake_quick_ramp), .irq(irq));
	dps_host u_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// ==========================================================
	// expectations
	function automatic logic [15:0] qs_final(input logic [15:0] c);
		return (c == QS_SLOW_HOLD || c == QS_QUICK_HOLD) ? SW_QSTOP : SW_SW_ON_DIS;
	endfunction
	function automatic int ramp_len(input logic [15:0] c);
		return (c == QS_SLOW_OFF || c == QS_SLOW_HOLD) ? int'(SLOW_RAMP_CYC) : int'(QUICK_RAMP_CYC);
	endfunction
	// ==========================================================
	// helpers
	task automatic give_verdict;
		error_cnt += u_host.tmo;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wc(input logic [IDX_W-1:0] i, input logic [15:0] v);
		u_host.wr(i, v, r);
		if (u_host.tmo != 0)
			give_verdict();
		`CHK("write response", RESP_OKAY, r)
	endtask
	task automatic rg(input logic [IDX_W-1:0] i, input logic [15:0] e, input logic [1:0] er);
		u_host.rd(i, d, r);
		if (u_host.tmo != 0)
			give_verdict();
		`CHK("read data", {16'h0000, e}, d)
		`CHK("read response", er, r)
	endtask
	// bounded: a ramp that never ends must not hang the run
	task automatic brk_wait;
		n = 0;
		while (braking === 1'b1 && n < 1500) begin
			@(posedge aclk);
			n++;
		end
		if (n >= 1500) begin
			error_cnt++;
			give_verdict();
		end
	endtask
	task automatic to_op;
		wc(IDX_CMD, (16'($random(seed)) & 16'hFF78) | 16'h0006);
		rg(IDX_STAT, SW_READY, RESP_OKAY);
		wc(IDX_CMD, 16'h0007);
		rg(IDX_STAT, SW_SWITCHED_ON, RESP_OKAY);
		wc(IDX_CMD, 16'h000F);
		wc(IDX_CMD, 16'h0007);
		rg(IDX_STAT, SW_SWITCHED_ON, RESP_OKAY);
		wc(IDX_CMD, 16'h000F);
		rg(IDX_STAT, SW_OP_EN, RESP_OKAY);
	endtask
	initial begin
		repeat (60000) @(posedge aclk);
		error_cnt++;
		give_verdict();
	end
	// ==========================================================
	// main sequence
	initial begin
		seed = 32'hBAD5DD12;
		error_cnt = 0;
		total_checks = 0;
		{aresetn, selftest_ok, unrecoverable_err, fault_req, limit_hit} = 5'h00;
		ce = 1'b1;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rg(IDX_STAT, SW_NOT_READY, RESP_OKAY);
		rg(IDX_QS_CODE, QS_CODE_RST, RESP_OKAY);
		rg(IDX_MODE_ACT, {8'h00, MODE_RST}, RESP_OKAY);
		rg(18'h00123, 16'h0000, RESP_SLVERR);
		selftest_ok <= 1'b1;
		// state follows a pin one edge later; the read must not be taken at that edge
		@(posedge aclk);
		rg(IDX_STAT, SW_SW_ON_DIS, RESP_OKAY);
		wc(IDX_CMD, 16'h000F);
		rg(IDX_STAT, SW_SW_ON_DIS, RESP_OKAY);
		for (int k = 0; k < 5; k++) begin
			to_op();
			wc(IDX_QS_CODE, codes[k]);
			// bits 3,1,0 stay set, so only a later rising edge may bring the drive back
			wc(IDX_CMD, 16'h000B);
			if (k > 0) begin
				rg(IDX_STAT, SW_QSTOP, RESP_OKAY);
				`CHK("braking", 1'b1, braking)
				`CHK("quick ramp", (k == 2 || k == 4), brake_quick_ramp)
				if (k == 1) begin
					m = 16'($random(seed)) & 16'h00FF;
					wc(IDX_MODE_REQ, m);
					rg(IDX_MODE_REQ, m, RESP_OKAY);
					rg(IDX_MODE_ACT, {8'h00, MODE_RST}, RESP_OKAY);
				end
				brk_wait();
				`CHK("ramp length", 1'b1, n >= ramp_len(codes[k]) - 24 && n <= ramp_len(codes[k]))
			end
			@(posedge aclk);
			rg(IDX_STAT, qs_final(codes[k]), RESP_OKAY);
			`CHK("power", k > 2, power_enabled)
			if (k > 2) begin
				wc(IDX_CMD, 16'h0002);
				wc(IDX_CMD, 16'h000F);
				rg(IDX_STAT, SW_OP_EN, RESP_OKAY);
				wc(IDX_CMD, 16'h0000);
				rg(IDX_STAT, SW_SW_ON_DIS, RESP_OKAY);
			end
		end
		rg(IDX_MODE_ACT, m, RESP_OKAY);
		wc(IDX_MODE_ACT, 16'h00FF ^ m);
		rg(IDX_MODE_ACT, m, RESP_OKAY);
		to_op();
		limit_hit <= 1'b1;
		@(posedge aclk);
		rg(IDX_STAT, SW_QSTOP, RESP_OKAY);
		limit_hit <= 1'b0;
		brk_wait();
		rg(IDX_STAT, SW_QSTOP, RESP_OKAY);
		wc(IDX_CMD, 16'h0000);
		to_op();
		fault_req <= 1'b1;
		@(posedge aclk);
		rg(IDX_STAT, SW_FAULT_REACT, RESP_OKAY);
		brk_wait();
		rg(IDX_STAT, SW_FAULT, RESP_OKAY);
		fault_req <= 1'b0;
		wc(IDX_CMD, 16'h0000);
		rg(IDX_STAT, SW_FAULT, RESP_OKAY);
		wc(IDX_CMD, 16'h0080);
		rg(IDX_STAT, SW_SW_ON_DIS, RESP_OKAY);
		// events stay hidden until unmasked, and a status read clears them
		`CHK("irq masked", 1'b0, irq)
		wc(IDX_IRQ_MASK, 16'h0007);
		rg(IDX_IRQ_MASK, 16'h0007, RESP_OKAY);
		`CHK("irq raised", 1'b1, irq)
		u_host.rd(IDX_IRQ_STAT, d, r);
		`CHK("irq status", 3'h7, d[2:0])
		rg(IDX_IRQ_STAT, 16'h0000, RESP_OKAY);
		`CHK("irq cleared", 1'b0, irq)
		ce <= 1'b0;
		@(posedge aclk);
		#1;
		`CHK("frozen arready", 1'b0, arready)
		@(posedge aclk);
		ce <= 1'b1;
		unrecoverable_err <= 1'b1;
		@(posedge aclk);
		rg(IDX_STAT, SW_NOT_READY, RESP_OKAY);
		unrecoverable_err <= 1'b0;
		wc(IDX_CMD, 16'h0006);
		rg(IDX_STAT, SW_NOT_READY, RESP_OKAY);
		give_verdict();
	end
endmodule
